// file: hw/svdc_core.sv
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module svdc_core
  import svdc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [14:0] trip_compare_above,
  input  wire logic        external_sense_input,
  input  wire logic        bandgap_stable,
  input  wire logic        internal_ref_stable,
  input  wire logic        device_idle,
  output logic             detector_power_on_ff,
  output logic [3:0]       trip_level_out_ff,
  output logic             irq_ff
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for the analog inputs; device_idle is used unsynchronised.

  logic [17:0] sync1_ff;
  logic [17:0] sync2_ff;
  logic        device_idle_s;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_ff <= 18'h00000;
      sync2_ff <= 18'h00000;
    end else begin
      sync1_ff <= {bandgap_stable, internal_ref_stable, external_sense_input, trip_compare_above};
      sync2_ff <= sync1_ff;
    end
  end

  assign device_idle_s = device_idle;

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  logic [15:0] control_ff;
  logic        status_ff;
  logic        mask_ff;
  logic        aw_held_ff;
  logic        w_held_ff;
  logic [31:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        do_write;
  logic        event_pulse;
  logic        clear_req;

  assign do_write = aw_held_ff && w_held_ff && !s_axi_bvalid;

  // Decodes a byte address into its register slot, 2'h3 when unmapped.
  function automatic logic [1:0] reg_slot(input logic [31:0] addr);
    unique case (addr[3:0])
      ADDR_CONTROL: reg_slot = 2'h0;
      ADDR_STATUS:  reg_slot = 2'h1;
      ADDR_MASK:    reg_slot = 2'h2;
      default:      reg_slot = 2'h3;
    endcase
    if (addr[31:4] != 28'h0000000) begin
      reg_slot = 2'h3;
    end
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff    <= 1'b0;
      w_held_ff     <= 1'b0;
      awaddr_ff     <= 32'h00000000;
      wdata_ff      <= 32'h00000000;
      wstrb_ff      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= AXI_OKAY;
    end else begin
      s_axi_awready <= !aw_held_ff && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held_ff && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_ff   <= 1'b0;
        w_held_ff    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (reg_slot(awaddr_ff) == 2'h3) ? AXI_SLVERR : AXI_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_ff <= CONTROL_RESET;
    end else if (do_write && reg_slot(awaddr_ff) == 2'h0) begin
      if (wstrb_ff[0]) begin
        control_ff[7:0] <= wdata_ff[7:0] & CONTROL_WRITE_MASK[7:0];
      end
      if (wstrb_ff[1]) begin
        control_ff[15:8] <= wdata_ff[15:8] & CONTROL_WRITE_MASK[15:8];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_ff <= 1'b0;
    end else if (do_write && reg_slot(awaddr_ff) == 2'h2 && wstrb_ff[0]) begin
      mask_ff <= wdata_ff[BIT_DETECT_EVENT];
    end
  end

  assign clear_req = do_write && reg_slot(awaddr_ff) == 2'h1 && wstrb_ff[0] && wdata_ff[BIT_DETECT_EVENT];

  // Set wins over a write-one clear landing in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_ff <= 1'b0;
    end else if (event_pulse) begin
      status_ff <= 1'b1;
    end else if (clear_req) begin
      status_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= (status_ff || event_pulse) && mask_ff && !(clear_req && !event_pulse);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel.

  logic [15:0] control_view;

  assign control_view = {control_ff[15:8], control_ff[7], sync2_ff[17], sync2_ff[16], 1'b0, control_ff[3:0]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= AXI_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= AXI_OKAY;
        unique case (reg_slot(s_axi_araddr))
          2'h0: s_axi_rdata <= {16'h0000, control_view};
          2'h1: s_axi_rdata <= {31'h00000000, status_ff};
          2'h2: s_axi_rdata <= {31'h00000000, mask_ff};
          2'h3: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= AXI_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Detector: level select, direction, qualification and edge detect.

  logic        running;
  logic        above_now;
  logic        tripped;
  logic        tripped_ff;
  logic [3:0]  level;

  assign level = control_ff[LEVEL_MSB:0];
  // Halting in idle parks the detector and clears the last comparison.
  assign running = control_ff[BIT_POWER_ENABLE] && !(control_ff[BIT_IDLE_HALT] && device_idle_s);

  always_comb begin
    if (level == LEVEL_EXTERNAL) begin
      above_now = sync2_ff[15];
    end else begin
      above_now = sync2_ff[level];
    end
  end

  // Comparator reports "at or above"; a low-going detect trips when not above or level equal cannot be resolved,
  // so the falling direction trips on the comparator reading low.
  assign tripped = control_ff[BIT_DIRECTION] ? above_now : !above_now;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tripped_ff <= 1'b0;
    end else if (running) begin
      tripped_ff <= tripped;
    end else begin
      tripped_ff <= 1'b0;
    end
  end

  assign event_pulse = running && sync2_ff[16] && tripped && !tripped_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      detector_power_on_ff <= 1'b0;
      trip_level_out_ff    <= 4'h0;
    end else begin
      detector_power_on_ff <= running;
      trip_level_out_ff    <= level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  property p_power_off_quiet;
    @(posedge aclk) disable iff (!aresetn)
      !control_ff[BIT_POWER_ENABLE] |=> !detector_power_on_ff;
  endproperty
  a_power_off_quiet: assert property (p_power_off_quiet) else $error("detector powered while disabled");

  property p_idle_halt;
    @(posedge aclk) disable iff (!aresetn)
      control_ff[BIT_IDLE_HALT] && device_idle_s |-> !event_pulse ##1 !detector_power_on_ff;
  endproperty
  a_idle_halt: assert property (p_idle_halt) else $error("detector active in idle with halt set");

  property p_no_flag_unstable;
    @(posedge aclk) disable iff (!aresetn)
      !sync2_ff[16] && !status_ff |=> !status_ff;
  endproperty
  a_no_flag_unstable: assert property (p_no_flag_unstable) else $error("flag set with unstable reference");

  property p_rise_sets_flag;
    @(posedge aclk) disable iff (!aresetn)
      running && sync2_ff[16] && control_ff[BIT_DIRECTION] && above_now && !tripped_ff |=> status_ff;
  endproperty
  a_rise_sets_flag: assert property (p_rise_sets_flag) else $error("rising crossing missed");

  property p_fall_sets_flag;
    @(posedge aclk) disable iff (!aresetn)
      running && sync2_ff[16] && !control_ff[BIT_DIRECTION] && !above_now && !tripped_ff |=> status_ff;
  endproperty
  a_fall_sets_flag: assert property (p_fall_sets_flag) else $error("falling crossing missed");

  property p_flag_sticky;
    @(posedge aclk) disable iff (!aresetn)
      status_ff && !clear_req |=> status_ff;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without clear");

  property p_irq_masked;
    @(posedge aclk) disable iff (!aresetn)
      !mask_ff |=> !irq_ff;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("interrupt while masked");

  property p_reserved_zero;
    @(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid && s_axi_rdata[31:16] == 16'h0000 |-> (control_ff & ~CONTROL_WRITE_MASK) == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved control bits stored");

  property p_external_select;
    @(posedge aclk) disable iff (!aresetn)
      level == LEVEL_EXTERNAL |-> above_now == sync2_ff[15];
  endproperty
  a_external_select: assert property (p_external_select) else $error("external input not selected");

  property p_write_answer;
    @(posedge aclk) disable iff (!aresetn)
      do_write |=> s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write response missing");

  c_event: cover property (@(posedge aclk) disable iff (!aresetn) event_pulse);
  c_irq: cover property (@(posedge aclk) disable iff (!aresetn) irq_ff);
  c_set_clear_race: cover property (@(posedge aclk) disable iff (!aresetn) event_pulse && clear_req);
  c_external: cover property (@(posedge aclk) disable iff (!aresetn) event_pulse && level == LEVEL_EXTERNAL);

endmodule

// file: shared/svdc_pkg.sv
package svdc_pkg;
  // Register byte addresses on the AXI4-Lite bus.
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_STATUS  = 4'h4;
  localparam logic [3:0] ADDR_MASK    = 4'h8;
  // Control register field positions.
  localparam int BIT_POWER_ENABLE = 15;
  localparam int BIT_IDLE_HALT    = 13;
  localparam int BIT_DIRECTION    = 7;
  localparam int BIT_BANDGAP_OK   = 6;
  localparam int BIT_INTREF_OK    = 5;
  localparam int LEVEL_MSB        = 3;
  localparam logic [15:0] CONTROL_WRITE_MASK = 16'ha08f;
  localparam logic [15:0] CONTROL_RESET      = 16'h0000;
  localparam logic [3:0]  LEVEL_EXTERNAL     = 4'hf;
  // Status and mask register layout.
  localparam int BIT_DETECT_EVENT = 0;
  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// file: verification/svdc_tb.sv
`timescale 1ns/1ps
module testbench
  import svdc_pkg::*;
;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, external_sense_input;
  logic        bandgap_stable, internal_ref_stable, device_idle, detector_power_on_ff, irq_ff, irq_mask;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb, trip_level_out_ff;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [14:0] trip_compare_above, sel;
  logic [33:0] exp_q[$];
  integer      seed;
  int          fails, num_checks;

  svdc_core u_svdc_core (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .trip_compare_above(trip_compare_above), .external_sense_input(external_sense_input),
    .bandgap_stable(bandgap_stable), .internal_ref_stable(internal_ref_stable), .device_idle(device_idle),
    .detector_power_on_ff(detector_power_on_ff), .trip_level_out_ff(trip_level_out_ff), .irq_ff(irq_ff)
  );

  initial aclk = 1'b0;
  always #2 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // The axw and axr tasks start one edge later, so no signal is assigned twice in one time step.
  task automatic axw(input logic [31:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check(s_axi_bresp, (a == ADDR_CONTROL || a == ADDR_STATUS || a == ADDR_MASK) ? AXI_OKAY : AXI_SLVERR);
  endtask

  task automatic axr(input logic [31:0] a, input logic [33:0] e);
    @(posedge aclk);
    exp_q.push_back(e);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      if (exp_q.size() == 0) check(34'h0, 34'h1);
      else check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    end
  end

  // Inputs start low, then a0/e0 are applied and the flag is read back clear, then a1/e1 are applied.
  task automatic trip(input logic [15:0] c, input logic [14:0] a0, input logic e0, input logic [14:0] a1,
                      input logic e1, input logic ex);
    trip_compare_above   <= 15'h0000;
    external_sense_input <= 1'b0;
    axw({28'h0, ADDR_CONTROL}, {16'h0000, c});
    repeat (6) @(posedge aclk);
    check(detector_power_on_ff, c[15] & !(c[13] & device_idle));
    check(trip_level_out_ff, c[3:0]);
    axw({28'h0, ADDR_STATUS}, 32'h1);
    trip_compare_above   <= a0;
    external_sense_input <= e0;
    repeat (6) @(posedge aclk);
    axr({28'h0, ADDR_STATUS}, 34'h0);
    trip_compare_above   <= a1;
    external_sense_input <= e1;
    repeat (6) @(posedge aclk);
    axr({28'h0, ADDR_STATUS}, {33'h0, ex});
    repeat (2) @(posedge aclk);
    check(irq_ff, ex & irq_mask);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #40000;
    fails++;
    close_out();
  end

  initial begin
    seed = 32'hed79352b;
    {fails, num_checks} = '0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, trip_compare_above} = '0;
    {external_sense_input, device_idle, irq_mask} = '0;
    s_axi_wstrb = 4'hf;
    bandgap_stable = 1'b1;
    internal_ref_stable = 1'b1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axr({28'h0, ADDR_CONTROL}, 34'h60);
    axr({28'h0, ADDR_MASK}, 34'h0);
    axr(32'h0000_0010, {AXI_SLVERR, 32'h0});
    axw(32'h0000_0010, 32'hffff_ffff);
    axr({28'h0, ADDR_CONTROL}, 34'h60);
    $display("test reset done");
    bandgap_stable      <= 1'b0;
    internal_ref_stable <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      axw({28'h0, ADDR_CONTROL}, d);
      axr({28'h0, ADDR_CONTROL}, {18'h0, d[15:0] & CONTROL_WRITE_MASK});
    end
    s_axi_wstrb <= 4'h1;
    axw({28'h0, ADDR_CONTROL}, 32'h0);
    axr({28'h0, ADDR_CONTROL}, {18'h0, d[15:8] & CONTROL_WRITE_MASK[15:8], 8'h00});
    s_axi_wstrb <= 4'hf;
    $display("test control done");
    bandgap_stable      <= 1'b1;
    internal_ref_stable <= 1'b1;
    axw({28'h0, ADDR_MASK}, 32'h1);
    irq_mask = 1'b1;
    for (int i = 0; i < 16; i++) begin
      sel = (i < 15) ? 15'h1 << i : 15'h0;
      trip(16'h8080 | i[15:0], 15'h7fff & ~sel, i < 15, 15'h7fff, 1'b1, 1'b1);
    end
    repeat (20) @(posedge aclk);
    axr({28'h0, ADDR_STATUS}, 34'h1);
    axw({28'h0, ADDR_STATUS}, 32'h0);
    axr({28'h0, ADDR_STATUS}, 34'h1);
    $display("test levels done");
    trip(16'h8003, 15'h7fff, 1'b1, 15'h7ff7, 1'b1, 1'b1);
    trip(16'h0082, 15'h0000, 1'b0, 15'h7fff, 1'b1, 1'b0);
    internal_ref_stable <= 1'b0;
    trip(16'h8085, 15'h0000, 1'b0, 15'h7fff, 1'b1, 1'b0);
    internal_ref_stable <= 1'b1;
    axw({28'h0, ADDR_MASK}, 32'h0);
    irq_mask = 1'b0;
    trip(16'h8082, 15'h0000, 1'b0, 15'h7fff, 1'b1, 1'b1);
    axw({28'h0, ADDR_MASK}, 32'h1);
    irq_mask = 1'b1;
    device_idle <= 1'b1;
    trip(16'ha082, 15'h0000, 1'b0, 15'h7fff, 1'b1, 1'b0);
    trip(16'h8082, 15'h0000, 1'b0, 15'h7fff, 1'b1, 1'b1);
    device_idle <= 1'b0;
    $display("test modes done");
    repeat (4) @(posedge aclk);
    close_out();
  end
endmodule
